// *** pmbts_regs.vh ***
`ifndef PMBTS_REGS_VH
`define PMBTS_REGS_VH
// Command codes answered on the bus.
`define PMBTS_CMD_OPERATION 8'h01
`define PMBTS_CMD_CLEAR_FAULTS 8'h03
`define PMBTS_CMD_STATUS_WORD 8'h79
`define PMBTS_CMD_STATUS_VOUT 8'h7A
`define PMBTS_CMD_STATUS_IOUT 8'h7B
`define PMBTS_CMD_STATUS_INPUT 8'h7C
`define PMBTS_CMD_STATUS_TEMP 8'h7D
`define PMBTS_CMD_STATUS_CML 8'h7E
`define PMBTS_CMD_INPUT_VOLTAGE_READING 8'h88
`define PMBTS_CMD_READ_VOUT 8'h8B
`define PMBTS_CMD_READ_IOUT 8'h8C
`define PMBTS_CMD_READ_TEMP 8'h8D
`define PMBTS_CMD_VOUT_CAL_OFF 8'hD4
`define PMBTS_CMD_VIN_CAL_OFF 8'hD5
`define PMBTS_CMD_VIN_CAL_GAIN 8'hD6
`define PMBTS_CMD_IOUT_CAL_OFF 8'hD7
`define PMBTS_CMD_IOUT_CAL_GAIN 8'hD8
// Operation byte: reset value, fields and margin codes.
`define PMBTS_OP_RESET 8'h88
`define PMBTS_OP_ON 7
`define PMBTS_OP_MHI 5
`define PMBTS_OP_MLO 4
`define PMBTS_OP_FIX 2'h2
`define PMBTS_MRG_OFF 2'h0
`define PMBTS_MRG_LOW 2'h1
`define PMBTS_MRG_HIGH 2'h2
// Fixed linear exponents, five-bit two's complement.
`define PMBTS_EXP_M3 5'h1D
`define PMBTS_EXP_M2 5'h1E
// Largest positive 11-bit mantissa and the blanking level (14 x 0.125A).
`define PMBTS_MANT_MAX 32'h0000_03FF
`define PMBTS_IOUT_BLANK 11'h00E
`define PMBTS_GAIN_SHIFT 13
// Sticky flag indices.
`define PMBTS_F_VOUT_OV 0
`define PMBTS_F_IOUT_OCF 1
`define PMBTS_F_IOUT_OCW 2
`define PMBTS_F_VIN_OV 3
`define PMBTS_F_VIN_UV 4
`define PMBTS_F_VIN_OFF 5
`define PMBTS_F_OT_F 6
`define PMBTS_F_OT_W 7
`define PMBTS_F_CML_CMD 8
`define PMBTS_F_CML_DATA 9
`define PMBTS_NFLAGS 10
// Bit positions inside the status bytes and the summary word.
`define PMBTS_B7 7
`define PMBTS_B6 6
`define PMBTS_B5 5
`define PMBTS_B4 4
`define PMBTS_B3 3
`define PMBTS_SW_VOUT 15
`define PMBTS_SW_IOUT 14
`define PMBTS_SW_INPUT 13
`define PMBTS_SW_PGN 11
`define PMBTS_SW_OFF 6
`define PMBTS_SW_VOV 5
`define PMBTS_SW_IOC 4
`define PMBTS_SW_VUV 3
`define PMBTS_SW_TEMP 2
`define PMBTS_SW_CML 1
`define PMBTS_BYTE_BITS 4'h8
`define PMBTS_LAST_BIT 4'h7
`endif

// *** pmbts_core.v ***
`timescale 1ns/100ps
`include "pmbts_regs.vh"

module pmbts_core #(
  parameter [10:0] TC_REF = 11'h064, // Reference temperature, 25 C in quarter degrees.
  parameter [7:0] TC_COEF = 8'h01, // Signed current slope per quarter degree.
  parameter TC_SHIFT = 12 // Scale of the slope as a right shift.
) (
  input wire ref_clk,
  input wire rst_n,
  input wire [6:0] slave_addr,
  input wire scl,
  input wire sda_i,
  output wire sda_o,
  output wire sda_oe,
  input wire [15:0] vout_raw,
  input wire [10:0] vin_raw,
  input wire [10:0] iout_raw,
  input wire iout_sinking,
  input wire [10:0] temp_raw,
  input wire [15:0] nv_vout_offset,
  input wire [10:0] nv_vin_offset,
  input wire [15:0] nv_vin_gain,
  input wire [10:0] nv_iout_offset,
  input wire [15:0] nv_iout_gain,
  input wire vout_ov_fault,
  input wire iout_oc_fault,
  input wire iout_oc_warn,
  input wire vin_ov_fault,
  input wire vin_uv_fault,
  input wire vin_low_off,
  input wire ot_fault,
  input wire ot_warn,
  input wire output_off,
  input wire power_good_n,
  output wire output_on,
  output wire margin_low,
  output wire margin_high
);

  // One-hot states of the serial slave.
  localparam [4:0] ST_IDLE = 5'h01;
  localparam [4:0] ST_RX = 5'h02;
  localparam [4:0] ST_RACK = 5'h04;
  localparam [4:0] ST_TX = 5'h08;
  localparam [4:0] ST_TACK = 5'h10;

  // Clamp a signed sum into a positive 11-bit mantissa.
  function [10:0] clamp_mant;
    input signed [31:0] v;
    reg [31:0] mx; // Saturation level at full width, cut down below.
    begin
      if (v < 0) begin
        clamp_mant = 11'h000;
      end else if (v > $signed(`PMBTS_MANT_MAX)) begin
        mx = `PMBTS_MANT_MAX;
        clamp_mant = mx[10:0];
      end else begin
        clamp_mant = v[10:0];
      end
    end
  endfunction

  // Gain and offset correction shared by input voltage and current.
  function [10:0] lin_corr;
    input [10:0] raw;
    input [15:0] gain;
    input [10:0] off;
    reg [26:0] prod;
    reg signed [31:0] sum;
    begin
      prod = raw * gain;
      sum = $signed({18'h0, prod[26:`PMBTS_GAIN_SHIFT]}) + $signed({{21{off[10]}}, off});
      lin_corr = clamp_mant(sum);
    end
  endfunction

  // True for every command code this slave answers.
  function cmd_known;
    input [7:0] c;
    begin
      case (c)
        `PMBTS_CMD_OPERATION, `PMBTS_CMD_CLEAR_FAULTS,
        `PMBTS_CMD_STATUS_WORD, `PMBTS_CMD_STATUS_VOUT,
        `PMBTS_CMD_STATUS_IOUT, `PMBTS_CMD_STATUS_INPUT,
        `PMBTS_CMD_STATUS_TEMP, `PMBTS_CMD_STATUS_CML,
        `PMBTS_CMD_INPUT_VOLTAGE_READING, `PMBTS_CMD_READ_VOUT,
        `PMBTS_CMD_READ_IOUT, `PMBTS_CMD_READ_TEMP,
        `PMBTS_CMD_VOUT_CAL_OFF, `PMBTS_CMD_VIN_CAL_OFF,
        `PMBTS_CMD_VIN_CAL_GAIN, `PMBTS_CMD_IOUT_CAL_OFF,
        `PMBTS_CMD_IOUT_CAL_GAIN: cmd_known = 1'b1;
        default: cmd_known = 1'b0;
      endcase
    end
  endfunction

  reg scl_s1_q, scl_s2_q, scl_s3_q; // Clock pin synchroniser and edge stage.
  reg sda_s1_q, sda_s2_q, sda_s3_q; // Data pin synchroniser and edge stage.
  reg [4:0] state_q; // Slave state.
  reg [3:0] bitcnt_q; // Bits moved in the current byte.
  reg [7:0] shreg_q; // Receive shifter.
  reg [7:0] tx_sh_q; // Transmit shifter, msb on the wire.
  reg [1:0] byte_idx_q; // 0 address, 1 command, 2 first data, 3 later.
  reg rw_q; // Read bit of the last matched address.
  reg [7:0] cmd_q; // Last command byte, kept across repeated start.
  reg hi_sent_q; // High byte of the answer already loaded.
  reg mack_q; // Master acknowledged the last byte sent.
  reg sda_oe_q; // Pull the data line low.
  reg [7:0] op_q; // Operation byte.
  reg set_cmd_q; // Pulse: unknown command seen.
  reg set_data_q; // Pulse: refused data seen.
  reg clr_q; // Pulse: clear-faults command seen.
  reg output_on_q, margin_low_q, margin_high_q; // Registered controls.
  reg [15:0] vout_q; // Corrected output voltage mantissa.
  reg [10:0] vin_q; // Corrected input voltage mantissa.
  reg [10:0] iout_q; // Corrected, compensated, blanked current mantissa.
  reg [10:0] temp_q; // Temperature mantissa.
  reg [`PMBTS_NFLAGS-1:0] flag_q; // Sticky fault and warning flags.

  wire scl_rise = scl_s2_q & ~scl_s3_q; // Clock line rose.
  wire scl_fall = ~scl_s2_q & scl_s3_q; // Clock line fell.
  // Start and stop are data edges while the clock line is high.
  wire bus_start = sda_s3_q & ~sda_s2_q & scl_s2_q & scl_s3_q;
  wire bus_stop = ~sda_s3_q & sda_s2_q & scl_s2_q & scl_s3_q;

  // Operation write check: 00xx, 0110 and 1010 in bits 5:2 only.
  wire [1:0] wr_mrg = shreg_q[`PMBTS_OP_MHI:`PMBTS_OP_MLO];
  wire wr_fix = shreg_q[`PMBTS_OP_MLO-1:`PMBTS_OP_MLO-2] == `PMBTS_OP_FIX;
  wire op_ok = (wr_mrg == `PMBTS_MRG_OFF) |
    (wr_fix & ((wr_mrg == `PMBTS_MRG_LOW) | (wr_mrg == `PMBTS_MRG_HIGH)));

  wire [`PMBTS_NFLAGS-1:0] flag_set; // Events that set the sticky flags.
  assign flag_set[`PMBTS_F_VOUT_OV] = vout_ov_fault;
  assign flag_set[`PMBTS_F_IOUT_OCF] = iout_oc_fault;
  assign flag_set[`PMBTS_F_IOUT_OCW] = iout_oc_warn;
  assign flag_set[`PMBTS_F_VIN_OV] = vin_ov_fault;
  assign flag_set[`PMBTS_F_VIN_UV] = vin_uv_fault;
  assign flag_set[`PMBTS_F_VIN_OFF] = vin_low_off;
  assign flag_set[`PMBTS_F_OT_F] = ot_fault;
  assign flag_set[`PMBTS_F_OT_W] = ot_warn;
  assign flag_set[`PMBTS_F_CML_CMD] = set_cmd_q;
  assign flag_set[`PMBTS_F_CML_DATA] = set_data_q;

  // Pin synchronisers; the first stage feeds only the second.
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      scl_s1_q <= 1'b1;
      scl_s2_q <= 1'b1;
      scl_s3_q <= 1'b1;
      sda_s1_q <= 1'b1;
      sda_s2_q <= 1'b1;
      sda_s3_q <= 1'b1;
    end else begin
      scl_s1_q <= scl;
      scl_s2_q <= scl_s1_q;
      scl_s3_q <= scl_s2_q;
      sda_s1_q <= sda_i;
      sda_s2_q <= sda_s1_q;
      sda_s3_q <= sda_s2_q;
    end
  end

  // Sticky flags: an event in the clearing cycle wins over the clear.
  genvar gi;
  generate
    for (gi = 0; gi < `PMBTS_NFLAGS; gi = gi + 1) begin : g_flag
      always @(posedge ref_clk) begin
        if (!rst_n) begin
          flag_q[gi] <= 1'b0;
        end else begin
          flag_q[gi] <= flag_set[gi] | (flag_q[gi] & ~clr_q);
        end
      end
    end
  endgenerate

  // Category bytes; unsupported positions are tied to zero.
  reg [7:0] st_vout, st_iout, st_input, st_temp, st_cml;
  reg [15:0] st_word;
  always @* begin
    st_vout = 8'h00;
    st_iout = 8'h00;
    st_input = 8'h00;
    st_temp = 8'h00;
    st_cml = 8'h00; // PEC is not checked, so bit 5 never rises.
    st_vout[`PMBTS_B7] = flag_q[`PMBTS_F_VOUT_OV];
    st_iout[`PMBTS_B7] = flag_q[`PMBTS_F_IOUT_OCF];
    st_iout[`PMBTS_B5] = flag_q[`PMBTS_F_IOUT_OCW];
    st_input[`PMBTS_B7] = flag_q[`PMBTS_F_VIN_OV];
    st_input[`PMBTS_B4] = flag_q[`PMBTS_F_VIN_UV];
    st_input[`PMBTS_B3] = flag_q[`PMBTS_F_VIN_OFF];
    st_temp[`PMBTS_B7] = flag_q[`PMBTS_F_OT_F];
    st_temp[`PMBTS_B6] = flag_q[`PMBTS_F_OT_W];
    st_cml[`PMBTS_B7] = flag_q[`PMBTS_F_CML_CMD];
    st_cml[`PMBTS_B6] = flag_q[`PMBTS_F_CML_DATA];
    // The summary word ORs the category bytes and adds the off and power-good inputs.
    st_word = 16'h0000;
    st_word[`PMBTS_SW_VOUT] = |st_vout;
    st_word[`PMBTS_SW_IOUT] = |st_iout;
    st_word[`PMBTS_SW_INPUT] = |st_input;
    st_word[`PMBTS_SW_PGN] = power_good_n;
    st_word[`PMBTS_SW_OFF] = output_off;
    st_word[`PMBTS_SW_VOV] = st_vout[`PMBTS_B7];
    st_word[`PMBTS_SW_IOC] = st_iout[`PMBTS_B7];
    st_word[`PMBTS_SW_VUV] = st_input[`PMBTS_B4];
    st_word[`PMBTS_SW_TEMP] = |st_temp;
    st_word[`PMBTS_SW_CML] = |st_cml;
  end

  // Current correction and temperature compensation, before blanking.
  reg [10:0] i_corr;
  reg signed [11:0] t_delta;
  reg signed [31:0] t_prod;
  reg signed [31:0] i_sum;
  reg [10:0] i_comp;
  reg signed [17:0] v_sum;
  always @* begin
    i_corr = lin_corr(iout_raw, nv_iout_gain, nv_iout_offset);
    t_delta = $signed({temp_raw[10], temp_raw}) - $signed({TC_REF[10], TC_REF});
    t_prod = $signed({20'h0_0000, 1'b0, i_corr}) * $signed({{20{t_delta[11]}}, t_delta})
      * $signed({{24{TC_COEF[7]}}, TC_COEF});
    i_sum = $signed({21'h00_0000, i_corr}) + (t_prod >>> TC_SHIFT);
    i_comp = clamp_mant(i_sum);
    v_sum = $signed({2'h0, vout_raw}) + $signed({{2{nv_vout_offset[15]}}, nv_vout_offset});
  end

  // Readings are refreshed every cycle from the converter values.
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      vout_q <= 16'h0000;
      vin_q <= 11'h000;
      iout_q <= 11'h000;
      temp_q <= 11'h000;
    end else begin
      // Out-of-range sums saturate instead of wrapping.
      if (v_sum < 0) begin
        vout_q <= 16'h0000;
      end else if (v_sum[16]) begin
        vout_q <= 16'hFFFF;
      end else begin
        vout_q <= v_sum[15:0];
      end
      vin_q <= lin_corr(vin_raw, nv_vin_gain, nv_vin_offset);
      // Sinking current and small loads both read as zero.
      if (iout_sinking || i_comp < `PMBTS_IOUT_BLANK) begin
        iout_q <= 11'h000;
      end else begin
        iout_q <= i_comp;
      end
      temp_q <= temp_raw;
    end
  end

  // Answer word for the current command.
  reg [15:0] rd_word;
  always @* begin
    case (cmd_q)
      `PMBTS_CMD_OPERATION: rd_word = {8'h00, op_q};
      `PMBTS_CMD_STATUS_WORD: rd_word = st_word;
      `PMBTS_CMD_STATUS_VOUT: rd_word = {8'h00, st_vout};
      `PMBTS_CMD_STATUS_IOUT: rd_word = {8'h00, st_iout};
      `PMBTS_CMD_STATUS_INPUT: rd_word = {8'h00, st_input};
      `PMBTS_CMD_STATUS_TEMP: rd_word = {8'h00, st_temp};
      `PMBTS_CMD_STATUS_CML: rd_word = {8'h00, st_cml};
      `PMBTS_CMD_READ_VOUT: rd_word = vout_q;
      `PMBTS_CMD_INPUT_VOLTAGE_READING: rd_word = {`PMBTS_EXP_M3, vin_q};
      `PMBTS_CMD_READ_IOUT: rd_word = {`PMBTS_EXP_M3, iout_q};
      `PMBTS_CMD_READ_TEMP: rd_word = {`PMBTS_EXP_M2, temp_q};
      `PMBTS_CMD_VOUT_CAL_OFF: rd_word = nv_vout_offset;
      `PMBTS_CMD_VIN_CAL_OFF: rd_word = {`PMBTS_EXP_M3, nv_vin_offset};
      `PMBTS_CMD_VIN_CAL_GAIN: rd_word = nv_vin_gain;
      `PMBTS_CMD_IOUT_CAL_OFF: rd_word = {`PMBTS_EXP_M3, nv_iout_offset};
      `PMBTS_CMD_IOUT_CAL_GAIN: rd_word = nv_iout_gain;
      default: rd_word = 16'h0000;
    endcase
  end

  // Serial slave. Bytes shift in on rising clock, answers change on falling clock.
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      bitcnt_q <= 4'h0;
      shreg_q <= 8'h00;
      tx_sh_q <= 8'h00;
      byte_idx_q <= 2'h0;
      rw_q <= 1'b0;
      cmd_q <= 8'h00;
      hi_sent_q <= 1'b0;
      mack_q <= 1'b0;
      sda_oe_q <= 1'b0;
      op_q <= `PMBTS_OP_RESET;
      set_cmd_q <= 1'b0;
      set_data_q <= 1'b0;
      clr_q <= 1'b0;
    end else begin
      set_cmd_q <= 1'b0;
      set_data_q <= 1'b0;
      clr_q <= 1'b0;
      if (bus_start) begin
        // A start, repeated or not, always restarts address reception.
        state_q <= ST_RX;
        bitcnt_q <= 4'h0;
        byte_idx_q <= 2'h0;
        sda_oe_q <= 1'b0;
      end else if (bus_stop) begin
        state_q <= ST_IDLE;
        sda_oe_q <= 1'b0;
      end else begin
        case (state_q)
          ST_IDLE: begin
            sda_oe_q <= 1'b0;
          end
          ST_RX: begin
            if (scl_rise) begin
              shreg_q <= {shreg_q[6:0], sda_s2_q};
              bitcnt_q <= bitcnt_q + 4'h1;
            end else if (scl_fall && bitcnt_q == `PMBTS_BYTE_BITS) begin
              bitcnt_q <= 4'h0;
              if (byte_idx_q == 2'h0) begin
                // Only our own address is acknowledged.
                if (shreg_q[7:1] == slave_addr) begin
                  rw_q <= shreg_q[0];
                  hi_sent_q <= 1'b0;
                  sda_oe_q <= 1'b1;
                  state_q <= ST_RACK;
                end else begin
                  state_q <= ST_IDLE;
                end
              end else begin
                sda_oe_q <= 1'b1;
                state_q <= ST_RACK;
                if (byte_idx_q == 2'h1) begin
                  cmd_q <= shreg_q;
                  set_cmd_q <= ~cmd_known(shreg_q);
                  clr_q <= shreg_q == `PMBTS_CMD_CLEAR_FAULTS;
                end else if (cmd_q == `PMBTS_CMD_OPERATION && byte_idx_q == 2'h2
                  && op_ok) begin
                  // Bits 6, 3:0 are read-only and keep their fixed values.
                  op_q <= {shreg_q[`PMBTS_OP_ON], 1'b0, wr_mrg, `PMBTS_OP_FIX, 2'h0};
                end else begin
                  // Bad margin codes and writes to read-only data are refused.
                  set_data_q <= 1'b1;
                end
              end
            end
          end
          ST_RACK: begin
            if (scl_fall) begin
              if (rw_q) begin
                // Low byte goes out first.
                state_q <= ST_TX;
                tx_sh_q <= rd_word[7:0];
                sda_oe_q <= ~rd_word[7];
              end else begin
                state_q <= ST_RX;
                sda_oe_q <= 1'b0;
                if (byte_idx_q != 2'h3) begin
                  byte_idx_q <= byte_idx_q + 2'h1;
                end
              end
            end
          end
          ST_TX: begin
            if (scl_fall) begin
              if (bitcnt_q == `PMBTS_LAST_BIT) begin
                bitcnt_q <= 4'h0;
                sda_oe_q <= 1'b0;
                state_q <= ST_TACK;
              end else begin
                bitcnt_q <= bitcnt_q + 4'h1;
                tx_sh_q <= {tx_sh_q[6:0], 1'b0};
                sda_oe_q <= ~tx_sh_q[6];
              end
            end
          end
          ST_TACK: begin
            if (scl_rise) begin
              mack_q <= ~sda_s2_q;
            end else if (scl_fall) begin
              if (mack_q) begin
                // High byte next; anything beyond the word reads zero.
                state_q <= ST_TX;
                hi_sent_q <= 1'b1;
                tx_sh_q <= hi_sent_q ? 8'h00 : rd_word[15:8];
                sda_oe_q <= hi_sent_q ? 1'b1 : ~rd_word[15];
              end else begin
                state_q <= ST_IDLE;
              end
            end
          end
          default: begin
            state_q <= ST_IDLE;
            sda_oe_q <= 1'b0;
          end
        endcase
      end
    end
  end

  // Margin controls follow the stored operation byte.
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      output_on_q <= 1'b0;
      margin_low_q <= 1'b0;
      margin_high_q <= 1'b0;
    end else begin
      output_on_q <= op_q[`PMBTS_OP_ON];
      margin_low_q <= op_q[`PMBTS_OP_MHI:`PMBTS_OP_MLO] == `PMBTS_MRG_LOW;
      margin_high_q <= op_q[`PMBTS_OP_MHI:`PMBTS_OP_MLO] == `PMBTS_MRG_HIGH;
    end
  end

  // The line is open drain, so the driven level is always low.
  assign sda_o = 1'b0;
  assign sda_oe = sda_oe_q;
  assign output_on = output_on_q;
  assign margin_low = margin_low_q;
  assign margin_high = margin_high_q;

endmodule

// *** pmbts_core_properties.sv ***
`timescale 1ns/100ps
// Pin-level checks of the core's bus side and its control outputs.
module pmbts_core_properties (
  input wire ref_clk,
  input wire rst_n,
  input wire scl,
  input wire sda_o,
  input wire sda_oe,
  input wire output_on,
  input wire margin_low,
  input wire margin_high
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  reg [7:0] lo_cnt_q; // Cycles with the bus clock low, saturating.
  reg [7:0] hi_cnt_q; // Cycles with the bus clock high, saturating.
  wire [7:0] lo_cnt_d = scl ? 8'h00 : lo_cnt_q + {7'h00, lo_cnt_q != 8'hFF};
  wire [7:0] hi_cnt_d = !scl ? 8'h00 : hi_cnt_q + {7'h00, hi_cnt_q != 8'hFF};
  // Both counters clear in reset so no stale count leaks into a new run.
  always @(posedge ref_clk) begin
    lo_cnt_q <= rst_n ? lo_cnt_d : 8'h00;
    hi_cnt_q <= rst_n ? hi_cnt_d : 8'h00;
  end
  property p_sda_o_tied;
    !sda_o;
  endproperty
  property p_margin_excl;
    !(margin_low && margin_high);
  endproperty
  // Reset must hold off the data line and the margin and enable levels.
  property p_reset_idle;
    @(posedge ref_clk) disable iff (1'b0)
      !rst_n |=> !sda_oe && !output_on && !margin_low && !margin_high;
  endproperty
  property p_rel_on;
    $rose(rst_n) |-> ##[1:2] (output_on && !margin_low && !margin_high);
  endproperty
  // The data line only moves while the bus clock is low.
  property p_sda_scl_low;
    $changed(sda_oe) |-> !scl;
  endproperty
  property p_sda_lag;
    $changed(sda_oe) |-> (lo_cnt_q >= 8'h01) && (lo_cnt_q <= 8'h08);
  endproperty
  property p_idle_release;
    hi_cnt_q > 8'h28 |-> !sda_oe;
  endproperty
  property p_idle_stable;
    hi_cnt_q > 8'h28 |-> $stable({output_on, margin_low, margin_high});
  endproperty
  a_sda_o_tied: assert property (p_sda_o_tied) else $error("sda_o not tied low");
  a_margin_excl: assert property (p_margin_excl) else $error("both margins on");
  a_reset_idle: assert property (p_reset_idle) else $error("outputs active in reset");
  a_rel_on: assert property (p_rel_on) else $error("operation reset value wrong");
  a_sda_scl_low: assert property (p_sda_scl_low) else $error("sda moved, scl high");
  a_sda_lag: assert property (p_sda_lag) else $error("sda change mistimed");
  a_idle_release: assert property (p_idle_release) else $error("sda held on idle");
  a_idle_stable: assert property (p_idle_stable) else $error("control moved on idle");
  c_low: cover property ($rose(margin_low));
  c_high: cover property ($rose(margin_high));
  c_ack: cover property ($rose(sda_oe));
  c_off: cover property ($fell(output_on));
endmodule

bind pmbts_core pmbts_core_properties pmbts_core_properties_inst (
  .ref_clk(ref_clk), .rst_n(rst_n), .scl(scl), .sda_o(sda_o), .sda_oe(sda_oe),
  .output_on(output_on), .margin_low(margin_low), .margin_high(margin_high)
);

// *** pmbts_host.sv ***
`timescale 1ns/100ps
// Bus host: open-drain data; the clock stands high outside frames.
module pmbts_host (
  input wire ref_clk,
  input wire sda,
  output reg scl,
  output reg sda_pull
);
  integer nacks; // Bytes we wrote that the device left unanswered.
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
    nacks = 0;
  end
  // Waits n cycles, then moves both lines just after the edge.
  task automatic step(input integer n, input logic c, input logic p);
    repeat (n) @(posedge ref_clk);
    scl <= c;
    sda_pull <= p;
  endtask
  // One 25-cycle bit: data set mid-low, sampled mid-high.
  task automatic bit_io(input logic b, output logic r);
    step(6, 1'b0, !b);
    step(7, 1'b1, !b);
    step(6, 1'b1, !b);
    r = sda;
    step(6, 1'b0, !b);
  endtask
  // Start or repeated start: data falls while the clock is high.
  task automatic start();
    step(6, 1'b0, 1'b0);
    step(6, 1'b1, 1'b0);
    step(6, 1'b1, 1'b1);
    step(6, 1'b0, 1'b1);
  endtask
  task automatic stop();
    step(6, 1'b0, 1'b1);
    step(7, 1'b1, 1'b1);
    step(6, 1'b1, 1'b0);
    step(12, 1'b1, 1'b0);
  endtask
  // One byte, most significant bit first, plus the acknowledge slot.
  task automatic xfer(input logic [7:0] d, input logic rd, input logic last,
                      output logic [7:0] q);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
      q[i] = r;
    end
    bit_io(rd ? last : 1'b1, r);
    if (!rd && r)
      nacks++;
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] c, input logic [7:0] d,
                    input logic has_d);
    logic [7:0] q;
    start();
    xfer({a, 1'b0}, 1'b0, 1'b0, q);
    xfer(c, 1'b0, 1'b0, q);
    if (has_d)
      xfer(d, 1'b0, 1'b0, q);
    stop();
  endtask
  // Word read: low byte comes first and is acknowledged, high byte is not.
  task automatic rd(input logic [6:0] a, input logic [7:0] c, output logic [15:0] v);
    logic [7:0] q;
    start();
    xfer({a, 1'b0}, 1'b0, 1'b0, q);
    xfer(c, 1'b0, 1'b0, q);
    start();
    xfer({a, 1'b1}, 1'b0, 1'b0, q);
    xfer(8'hFF, 1'b1, 1'b0, v[7:0]);
    xfer(8'hFF, 1'b1, 1'b1, v[15:8]);
    stop();
  endtask
endmodule

// *** pmbts_core_tb.sv ***
`timescale 1ns/100ps
`include "pmbts_regs.vh"
`define CHK(nm, e, g) begin \
  n_checks++; \
  if ((g) !== (e)) begin \
    failures++; \
    $display("ERROR %s expected %h seen %h", nm, e, g); \
  end \
end
// Bench: the host model reads and writes the core's registers.
module pmbts_core_tb;
  localparam logic [6:0] ADDR = 7'h2A; // Address given to the core.
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [6:0] addr = ADDR;
  logic sink = 1'b0;
  logic [9:0] flt = 10'h000; // Fault pulses; top two are off and power-good-negated.
  logic [10:0] iout_raw = 11'h064;
  logic [10:0] temp_raw = 11'h064; // Equals the reference, so no compensation.
  logic [10:0] vin_off = 11'h002;
  logic [10:0] iout_off = 11'h7FC; // Minus four counts.
  logic [15:0] vout_off = 16'hFFF0; // Minus sixteen counts.
  logic [15:0] v; // Last word read back.
  logic [10:0] mt [8] = '{11'h480, 11'h598, 11'h000, 11'h6A8, 11'h48C, 11'h6A8,
                          11'h6B8, 11'h694}; // {on, high, low, operation byte}.
  int failures = 0;
  int n_checks = 0;
  int cycles = 0;
  wire scl;
  wire sda_pull;
  wire sda_oe;
  wire output_on;
  wire margin_low;
  wire margin_high;
  wire sda = !(sda_oe || sda_pull); // Pulled up unless someone pulls low.
  always #2.5 ref_clk = !ref_clk;
  pmbts_core pmbts_core_inst (
    .ref_clk(ref_clk), .rst_n(rst_n), .slave_addr(addr), .scl(scl), .sda_i(sda),
    .sda_o(), .sda_oe(sda_oe), .vout_raw(16'hC000), .vin_raw(11'h190),
    .iout_raw(iout_raw), .iout_sinking(sink), .temp_raw(temp_raw),
    .nv_vout_offset(vout_off), .nv_vin_offset(vin_off), .nv_vin_gain(16'h3000),
    .nv_iout_offset(iout_off), .nv_iout_gain(16'h2000), .vout_ov_fault(flt[0]),
    .iout_oc_fault(flt[1]), .iout_oc_warn(flt[2]), .vin_ov_fault(flt[3]),
    .vin_uv_fault(flt[4]), .vin_low_off(flt[5]), .ot_fault(flt[6]), .ot_warn(flt[7]),
    .output_off(flt[8]), .power_good_n(flt[9]), .output_on(output_on),
    .margin_low(margin_low), .margin_high(margin_high));
  pmbts_host pmbts_host_inst (.ref_clk(ref_clk), .sda(sda), .scl(scl), .sda_pull(sda_pull));
  task automatic wrap_up();
    $display("Checks %0d, failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] c, input logic [7:0] d, input logic has_d);
    pmbts_host_inst.wr(ADDR, c, d, has_d);
  endtask
  task automatic rchk(input logic [7:0] c, input logic [15:0] e);
    pmbts_host_inst.rd(ADDR, c, v);
    `CHK($sformatf("reg_%h", c), e, v)
  endtask
  // A hung bus must still end the run with a verdict.
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 90000) begin
      failures++;
      wrap_up();
    end
  end
  initial begin
    repeat (16) @(posedge ref_clk);
    rst_n <= 1'b1;
    // A long idle bus first, so the idle-bus checks see their trigger.
    repeat (48) @(posedge ref_clk);
    `CHK("ctl", 3'b100, {output_on, margin_high, margin_low})
    rchk(`PMBTS_CMD_OPERATION, 16'h0088);
    for (int i = 0; i < 6; i++)
      rchk(8'(`PMBTS_CMD_STATUS_WORD + i), 16'h0000);
    // Every margin code, then two bad codes that must change nothing.
    foreach (mt[i]) begin
      wr(`PMBTS_CMD_OPERATION, mt[i][7:0], 1'b1);
      `CHK("ctl", mt[i][10:8], {output_on, margin_high, margin_low})
    end
    rchk(`PMBTS_CMD_STATUS_CML, 16'h0040);
    rchk(`PMBTS_CMD_OPERATION, 16'h00A8);
    wr(8'h55, 8'h00, 1'b0);
    rchk(`PMBTS_CMD_STATUS_CML, 16'h00C0);
    rchk(`PMBTS_CMD_STATUS_WORD, 16'h0002);
    wr(`PMBTS_CMD_CLEAR_FAULTS, 8'h00, 1'b0);
    rchk(`PMBTS_CMD_STATUS_CML, 16'h0000);
    // One-cycle fault pulses must stick until cleared.
    flt <= 10'h3FF;
    @(posedge ref_clk);
    flt <= 10'h300;
    rchk(`PMBTS_CMD_STATUS_VOUT, 16'h0080);
    rchk(`PMBTS_CMD_STATUS_IOUT, 16'h00A0);
    rchk(`PMBTS_CMD_STATUS_INPUT, 16'h0098);
    rchk(`PMBTS_CMD_STATUS_TEMP, 16'h00C0);
    rchk(`PMBTS_CMD_STATUS_WORD, 16'hE87C);
    wr(`PMBTS_CMD_CLEAR_FAULTS, 8'h00, 1'b0);
    rchk(`PMBTS_CMD_STATUS_WORD, 16'h0840);
    rchk(`PMBTS_CMD_READ_VOUT, 16'hBFF0);
    rchk(`PMBTS_CMD_VOUT_CAL_OFF, 16'hFFF0);
    rchk(`PMBTS_CMD_INPUT_VOLTAGE_READING, {`PMBTS_EXP_M3, 11'h25A});
    rchk(`PMBTS_CMD_VIN_CAL_OFF, {`PMBTS_EXP_M3, 11'h002});
    rchk(`PMBTS_CMD_VIN_CAL_GAIN, 16'h3000);
    rchk(`PMBTS_CMD_READ_IOUT, {`PMBTS_EXP_M3, 11'h060});
    rchk(`PMBTS_CMD_IOUT_CAL_OFF, {`PMBTS_EXP_M3, 11'h7FC});
    rchk(`PMBTS_CMD_IOUT_CAL_GAIN, 16'h2000);
    rchk(`PMBTS_CMD_READ_TEMP, {`PMBTS_EXP_M2, 11'h064});
    // Blanking edge: 13 counts read zero, 14 counts read through.
    iout_raw <= 11'h011;
    pmbts_host_inst.rd(ADDR, `PMBTS_CMD_READ_IOUT, v);
    `CHK("iout_blank", 11'h000, v[10:0])
    iout_raw <= 11'h012;
    rchk(`PMBTS_CMD_READ_IOUT, {`PMBTS_EXP_M3, 11'h00E});
    sink <= 1'b1;
    pmbts_host_inst.rd(ADDR, `PMBTS_CMD_READ_IOUT, v);
    `CHK("iout_sink", 11'h000, v[10:0])
    // Hot and cold sites move the current reading by the slope.
    sink <= 1'b0;
    iout_raw <= 11'h064;
    temp_raw <= 11'h164;
    rchk(`PMBTS_CMD_READ_IOUT, {`PMBTS_EXP_M3, 11'h066});
    temp_raw <= 11'h7F0;
    rchk(`PMBTS_CMD_READ_IOUT, {`PMBTS_EXP_M3, 11'h05D});
    rchk(`PMBTS_CMD_READ_TEMP, {`PMBTS_EXP_M2, 11'h7F0});
    pmbts_host_inst.wr(7'h2B, `PMBTS_CMD_CLEAR_FAULTS, 8'h00, 1'b0);
    `CHK("nacks", 2, pmbts_host_inst.nacks)
    wrap_up();
  end
endmodule
